// [cycle_seq_pkg.sv]
// Purpose: Shared constants and types for the machine cycle phase sequencer
// Assumes: 10 MHz core clock, one time period = two clock cycles
// Notes:   Bit positions of the instruction word and ring layout live here
package cycle_seq_pkg;

    localparam int WORD_W           = 16;
    localparam int OPCODE_W         = 6;
    localparam int OPCODE_HI        = 15;
    localparam int OPCODE_LO        = 10;
    localparam int OPERAND_HI       = 9;
    localparam int OPERAND_LO       = 0;
    localparam int INDIRECT_BIT     = 15;
    localparam int FULL_ADDR_W      = 15;
    localparam int PAGE_OFS_W       = 10;
    localparam int LAST_PERIOD      = 7;
    localparam int SEVENTH_PERIOD   = 6;

    // Ring with stage k spanning periods k and k+1; stage 7 spans 7 and 0
    localparam logic [7:0] RING_RESTART   = 8'hc0;
    localparam logic [7:0] RING_CLEAR     = 8'h00;
    localparam logic [OPCODE_W-1:0] OPCODE_RST = 6'h00;
    localparam logic [WORD_W-1:0]   WORD_RST   = 16'h0000;

    typedef enum logic [2:0] {
        PH_FETCH,
        PH_INDIRECT,
        PH_EXECUTE,
        PH_INTERRUPT,
        PH_DMA
    } phase_e;

    // Time-period outputs bundled for the consumers
    typedef struct packed {
        logic [7:0] period;       // Single 200 ns periods
        logic [7:0] double_pair;  // 400 ns pulses, index k = periods k,k+1
        logic       late_strobe;  // Last half of final period
    } timing_s;

    // Requests from the instruction decoder during the current cycle
    typedef struct packed {
        logic mem_ref;            // Memory-reference instruction
        logic multi_phase;        // Needs an execute cycle
        logic read_req;           // Core read wanted this cycle
        logic write_req;          // Core write wanted this cycle
    } decode_s;

endpackage : cycle_seq_pkg

// [machine_cycle_phase_sequencer.sv]
// Purpose: Time-period ring, phase generator and instruction word holding
// Assumes: Panel and decoder inputs are on core_clk; link pins are synced
// Notes:   Two interleaved enables, one ring step every two cycles, are the phases
`timescale 1ns/1ps

// Contract
// RULE1: Eight 200 ns periods in order, each rising as previous falls, wrapping.
// RULE2: Double-length 400 ns pulses across each consecutive pair of periods.
// RULE3: Late strobe only in final quarter of the eighth period; code asserts it for the whole last half.
// RULE4: Ring of eight stages, exactly two adjacent set in steady operation.
// RULE5: Once per cycle the set pair spans wrap stage and first pair stage.
// RULE6: Alternate phases clear trailing stage and set stage ahead of leader.
// RULE7: Random power-up state corrected within one cycle, output starting at seventh.
// RULE8: Seventh period output stays asserted when the arithmetic option is absent.
// RULE9: Write level stays asserted when neither parity nor protect option present.
// RULE10: Core read and write pulses come from plain combinational gating.
// RULE11: Six-bit opcode register captures word bits 15 to 10 and holds them.
// RULE12: Bits 9 to 0 go straight from transfer register to decoder.
// RULE13: Operand read overwrites transfer word; held opcode steers the rest.
// RULE14: Fetch routes program counter over R bus unchanged into address register.
// RULE15: Exactly one of the phases asserted for each 1.6 us machine cycle.
// RULE16: Every instruction starts with a fetch cycle; some finish there.
// RULE17: Indirect phase entered only for memory-reference words with bit 15 set.
// RULE18: Direct uses bits 9..0 within page; indirect word gives 15-bit address.
// RULE19: Indirect repeats while fetched word bit 15 set, then one final cycle.
// RULE20: Indirect follows only fetch or another indirect.
// RULE21: Execute follows only fetch or indirect.
// RULE22: Instruction ends with fetch if single-phase, else with execute.
// RULE23: Interrupt phase may be inserted between any two phases.
// RULE24: A fifth phase is reserved for direct memory access.
// RULE25: Phase changes only at the end of the eighth period.
module machine_cycle_phase_sequencer #(
    parameter bit EAU_PRESENT     = 1'b0, // Extended arithmetic option fitted
    parameter bit PARITY_PRESENT  = 1'b0, // Parity error option fitted
    parameter bit PROTECT_PRESENT = 1'b0  // Memory protect option fitted
) (
    input  wire logic                     core_clk,       // 10 MHz clock
    input  wire logic                     sys_rst,        // Async reset, high
    input  wire logic                     ring_scramble,  // Test: load random ring
    input  wire logic [7:0]               ring_seed,      // Test: ring image
    input  wire logic                     run,            // Panel run enable
    input  wire logic                     panel_read,     // Panel memory display
    input  wire logic                     panel_write,    // Panel memory deposit
    input  wire cycle_seq_pkg::decode_s   decode,         // Decoder requests
    input  wire logic                     int_req_pin,    // Interrupt request pin
    input  wire logic                     dma_req_pin,    // DMA cycle request pin
    input  wire logic                     eau_write_en,   // Option write-level gate
    input  wire logic [15:0]              mem_word,       // Word read from core
    input  wire logic                     mem_word_vld,   // Word read strobe
    input  wire logic [14:0]              pc_value,       // Program counter
    output cycle_seq_pkg::timing_s        timing,         // Period pulses
    output logic                          clock_phase_a,  // Phase A enable
    output logic                          clock_phase_b,  // Phase B enable
    output logic                          seventh_time_period, // Period 6 pulse
    output logic                          late_cycle_strobe,   // Late T7 strobe
    output logic                          memory_write_level,  // Write level
    output logic                          mem_read_pulse, // Core read control
    output logic                          mem_write_pulse,// Core write control
    output logic                          ring_stage_wrap,     // Stage 7/0 set
    output logic                          ring_stage_first_pair, // Stage 0/1 set
    output logic                          first_double_period_pulse, // T0+T1
    output logic [3:0]                    phase_onehot,   // Fetch/ind/exe/int
    output logic                          phase_dma,      // Reserved DMA phase
    output logic [5:0]                    opcode,         // Held opcode bits
    output logic [9:0]                    operand_field,  // Direct decoder bits
    output logic [15:0]                   transfer_word,  // Transfer register
    output logic [14:0]                   addr_out,       // Memory address reg
    output logic                          instr_done      // Instruction complete
);

    logic [1:0] div_r;          // Divide-by-four of core_clk
    logic [7:0] ring_r;         // Eight latch stages
    logic [7:0] ring_nxt;
    logic [7:0] period;
    logic       pair_ok;
    logic       int_meta_r, int_sync_r, dma_meta_r, dma_sync_r;
    cycle_seq_pkg::phase_e phase_r, phase_nxt;
    logic [5:0]  opcode_r;
    logic [15:0] tword_r;
    logic [14:0] maddr_r;
    logic        cycle_end;
    logic        in_chain_r;    // Indirect chain still carries bit 15

    // Stage count in a ring image
    function automatic logic [3:0] ones8(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'b000, v[i]};
        end
        return n;
    endfunction : ones8

    // Two set stages that are neighbours, including across the wrap
    function automatic logic adjacent_pair(input logic [7:0] v);
        logic ok;
        ok = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (v[i] && v[(i + 1) % 8]) begin
                ok = 1'b1;
            end
        end
        return ok && (ones8(v) == 4'h2);
    endfunction : adjacent_pair

    // Divider; reset at all ones so the restart pair gets a full period 6
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_r <= '1;
        end else begin
            div_r <= div_r + 2'h1;
        end
    end
    assign clock_phase_a = div_r[0] & div_r[1];   // RULE6
    assign clock_phase_b = div_r[0] & ~div_r[1];  // RULE6

    // Leap-frog advance; phase A steps even stages, phase B odd stages
    always_comb begin
        ring_nxt = ring_r;
        pair_ok  = adjacent_pair(ring_r);
        for (int k = 0; k < 8; k++) begin
            if ((k % 2 == 0) ? clock_phase_a : clock_phase_b) begin
                // Stage k sets when the pair sits just behind it, clears when it trails
                ring_nxt[k] = (ring_r[(k + 7) % 8] & ring_r[(k + 6) % 8]) |
                              (ring_r[k] & ~ring_r[(k + 1) % 8]);     // RULE6
            end
        end
        // Correction gating: any bad image restarts at the stage 5 and 6 pair, giving period 6
        if (!pair_ok) begin
            ring_nxt = cycle_seq_pkg::RING_RESTART >> 1;  // RULE7
        end
    end

    // Ring stages; a scramble load models the random power-up state
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ring_r <= cycle_seq_pkg::RING_CLEAR;
        end else if (ring_scramble) begin
            ring_r <= ring_seed;                           // RULE7
        end else begin
            ring_r <= ring_nxt;                            // RULE4
        end
    end

    // Period k is where stages k-1 and k overlap: stage k-1 = k-1..k
    generate
        for (genvar k = 0; k < 8; k++) begin : g_period
            assign period[k] = ring_r[(k + 7) % 8] & ring_r[k] & pair_ok; // RULE1
            assign timing.double_pair[k] = period[k] | period[(k + 1) % 8]; // RULE2
        end
    endgenerate
    assign timing.period = period;

    // Late strobe spans the whole last core cycle of period 7, its second half
    assign timing.late_strobe = period[cycle_seq_pkg::LAST_PERIOD] & div_r[0]; // RULE3
    assign late_cycle_strobe  = timing.late_strobe;                            // RULE3
    assign cycle_end = period[cycle_seq_pkg::LAST_PERIOD] & div_r[0];

    assign ring_stage_wrap           = ring_r[7];                   // RULE5
    assign ring_stage_first_pair     = ring_r[0];                   // RULE5
    assign first_double_period_pulse = timing.double_pair[0];       // RULE2

    // Option pull-downs missing means the line floats true
    assign seventh_time_period = EAU_PRESENT ? period[cycle_seq_pkg::SEVENTH_PERIOD]
                                             : 1'b1;                // RULE8
    assign memory_write_level  = (PARITY_PRESENT || PROTECT_PRESENT) ? eau_write_en
                                             : 1'b1;                // RULE9

    // Core timing gates: read early in the cycle, write late
    assign mem_read_pulse  = (period[1] | period[2]) &
                             (panel_read | (run & decode.read_req));    // RULE10
    assign mem_write_pulse = (period[5] | period[6]) & memory_write_level &
                             (panel_write | (run & decode.write_req));  // RULE10

    // Request pins come from outside and are synchronised first
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            int_meta_r <= 1'b0;
            int_sync_r <= 1'b0;
            dma_meta_r <= 1'b0;
            dma_sync_r <= 1'b0;
        end else begin
            int_meta_r <= int_req_pin;
            int_sync_r <= int_meta_r;
            dma_meta_r <= dma_req_pin;
            dma_sync_r <= dma_meta_r;
        end
    end

    // Next phase choice, applied only at the close of the cycle
    always_comb begin
        phase_nxt = cycle_seq_pkg::PH_FETCH;
        unique case (phase_r)
            cycle_seq_pkg::PH_FETCH: begin
                if (decode.mem_ref && tword_r[cycle_seq_pkg::INDIRECT_BIT]) begin
                    phase_nxt = cycle_seq_pkg::PH_INDIRECT;  // RULE17
                end else if (decode.multi_phase) begin
                    phase_nxt = cycle_seq_pkg::PH_EXECUTE;   // RULE21
                end else begin
                    phase_nxt = cycle_seq_pkg::PH_FETCH;     // RULE22
                end
            end
            cycle_seq_pkg::PH_INDIRECT: begin
                // Chain continues while the address word carries bit 15
                if (in_chain_r) begin
                    phase_nxt = cycle_seq_pkg::PH_INDIRECT;  // RULE19 RULE20
                end else begin
                    phase_nxt = cycle_seq_pkg::PH_EXECUTE;   // RULE21
                end
            end
            cycle_seq_pkg::PH_EXECUTE:   phase_nxt = cycle_seq_pkg::PH_FETCH; // RULE22
            cycle_seq_pkg::PH_INTERRUPT: phase_nxt = cycle_seq_pkg::PH_FETCH; // RULE23
            cycle_seq_pkg::PH_DMA:       phase_nxt = cycle_seq_pkg::PH_FETCH; // RULE24
            default:                     phase_nxt = cycle_seq_pkg::PH_FETCH;
        endcase
        // Interrupt slips in at a phase boundary; DMA outranks it
        if (dma_sync_r) begin
            phase_nxt = cycle_seq_pkg::PH_DMA;               // RULE24
        end else if (int_sync_r && phase_r != cycle_seq_pkg::PH_INTERRUPT) begin
            phase_nxt = cycle_seq_pkg::PH_INTERRUPT;         // RULE23
        end
    end

    // Phase register; a held phase resumes in fetch after an insertion
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_r <= cycle_seq_pkg::PH_FETCH;              // RULE16
        end else if (cycle_end && run) begin
            phase_r <= phase_nxt;                            // RULE25
        end
    end

    // One-hot phase lamps, none asserted in the DMA phase
    assign phase_onehot = {phase_r == cycle_seq_pkg::PH_INTERRUPT,
                           phase_r == cycle_seq_pkg::PH_EXECUTE,
                           phase_r == cycle_seq_pkg::PH_INDIRECT,
                           phase_r == cycle_seq_pkg::PH_FETCH};    // RULE15
    assign phase_dma    = (phase_r == cycle_seq_pkg::PH_DMA);      // RULE24
    assign instr_done   = cycle_end && run &&
                          phase_nxt == cycle_seq_pkg::PH_FETCH &&
                          (phase_r == cycle_seq_pkg::PH_EXECUTE ||
                           phase_r == cycle_seq_pkg::PH_FETCH);     // RULE22

    // Transfer register takes every word read; operands overwrite the instruction
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tword_r <= cycle_seq_pkg::WORD_RST;
        end else if (mem_word_vld) begin
            tword_r <= mem_word;                             // RULE13
        end
    end

    // Opcode held only from instruction words read in fetch
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            opcode_r <= cycle_seq_pkg::OPCODE_RST;
        end else if (mem_word_vld && phase_r == cycle_seq_pkg::PH_FETCH) begin
            opcode_r <= mem_word[cycle_seq_pkg::OPCODE_HI:cycle_seq_pkg::OPCODE_LO]; // RULE11
        end
    end

    // Chain goes on while the word used as address had bit 15; operand read ends it
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            in_chain_r <= 1'b0;
        end else if (mem_word_vld && phase_r == cycle_seq_pkg::PH_INDIRECT) begin
            in_chain_r <= tword_r[cycle_seq_pkg::INDIRECT_BIT];   // RULE19
        end else if (mem_word_vld && phase_r == cycle_seq_pkg::PH_FETCH) begin
            in_chain_r <= 1'b1;
        end
    end

    // Address register: PC passed unchanged in fetch, page or full address after
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            maddr_r <= '0;
        end else if (period[0]) begin
            unique case (phase_r)
                cycle_seq_pkg::PH_FETCH:
                    maddr_r <= pc_value;                                   // RULE14
                cycle_seq_pkg::PH_INDIRECT:
                    maddr_r <= tword_r[cycle_seq_pkg::FULL_ADDR_W-1:0];    // RULE18
                cycle_seq_pkg::PH_EXECUTE:
                    maddr_r <= {pc_value[14:cycle_seq_pkg::PAGE_OFS_W],
                                tword_r[cycle_seq_pkg::OPERAND_HI:
                                        cycle_seq_pkg::OPERAND_LO]};       // RULE18
                default:
                    maddr_r <= maddr_r;
            endcase
        end
    end

    assign opcode        = opcode_r;                                       // RULE13
    assign operand_field = tword_r[cycle_seq_pkg::OPERAND_HI:
                                   cycle_seq_pkg::OPERAND_LO];             // RULE12
    assign transfer_word = tword_r;
    assign addr_out      = maddr_r;

endmodule : machine_cycle_phase_sequencer

// [seq_chk.sv]
// Purpose: Port-level assertions for the machine cycle phase sequencer
// Assumes: Options absent, async active-high reset, one clock
// Notes:   Ring checks wait for a settle count after reset or scramble
`timescale 1ns/1ps
module seq_chk (
    input wire logic                   core_clk,                  // Clock
    input wire logic                   sys_rst,                   // Async reset
    input wire logic                   ring_scramble,             // Ring image load
    input wire cycle_seq_pkg::timing_s timing,                    // Period pulses
    input wire logic                   clock_phase_a,             // Phase A enable
    input wire logic                   clock_phase_b,             // Phase B enable
    input wire logic                   seventh_time_period,       // Period 6 output
    input wire logic                   late_cycle_strobe,         // Late strobe
    input wire logic                   memory_write_level,        // Write level
    input wire logic                   ring_stage_wrap,           // Stage 7/0
    input wire logic                   ring_stage_first_pair,     // Stage 0/1
    input wire logic                   first_double_period_pulse, // Periods 0+1
    input wire logic [3:0]             phase_onehot,              // Phases
    input wire logic                   phase_dma,                 // DMA phase
    input wire logic [5:0]             opcode,                    // Held opcode
    input wire logic [9:0]             operand_field,             // Decoder bits
    input wire logic [15:0]            transfer_word,             // Transfer reg
    input wire logic [15:0]            mem_word,                  // Core word
    input wire logic                   mem_word_vld               // Word strobe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic [4:0] calm_r; // Cycles since reset or scramble, saturating

    // Random ring images need a full cycle to heal, so ring checks wait
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) calm_r <= 5'h00;
        else if (ring_scramble) calm_r <= 5'h00;
        else if (calm_r != 5'h14) calm_r <= calm_r + 5'h01;
    end

    period_onehot_a: assert property (calm_r == 5'h14 |-> $onehot(timing.period))
        else $error("period pulses not one-hot");
    period_walk_a: assert property (calm_r == 5'h14 && $rose(timing.period[7]) |->
        !late_cycle_strobe ##1 (timing.period[7] && late_cycle_strobe) ##1
        (timing.period[0] && !late_cycle_strobe) ##1 timing.period[0])
        else $error("period walk through wrap is wrong");
    double_pulse_a: assert property (calm_r == 5'h14 |->
        timing.double_pair == (timing.period | {timing.period[0], timing.period[7:1]})
        && first_double_period_pulse == timing.double_pair[0])
        else $error("double pulse does not cover its period pair");
    late_only_a: assert property (calm_r == 5'h14 && late_cycle_strobe |->
        timing.late_strobe && timing.period[7] && $past(timing.period[7]))
        else $error("late strobe outside the end of the last period");
    wrap_pair_a: assert property (calm_r == 5'h14 |->
        timing.period[0] == (ring_stage_wrap && ring_stage_first_pair))
        else $error("wrap stages do not match period zero");
    phase_alt_a: assert property (clock_phase_a |->
        !clock_phase_b ##1 (!clock_phase_a && !clock_phase_b) ##1 clock_phase_b ##2 clock_phase_a)
        else $error("clock phases do not alternate");
    options_off_a: assert property (seventh_time_period && memory_write_level)
        else $error("option outputs not held asserted");
    phase_single_a: assert property ($onehot({phase_dma, phase_onehot}))
        else $error("phase signals not exactly one");
    phase_hold_a: assert property (!$past(late_cycle_strobe) |->
        $stable({phase_dma, phase_onehot}))
        else $error("phase changed inside a machine cycle");
    indirect_src_a: assert property ($rose(phase_onehot[1]) |-> $past(phase_onehot[0]))
        else $error("indirect entered from a wrong phase");
    execute_src_a: assert property ($rose(phase_onehot[2]) |->
        $past(phase_onehot[1:0]) != 2'b00)
        else $error("execute entered from a wrong phase");
    opcode_take_a: assert property (mem_word_vld && phase_onehot[0] |=>
        opcode == $past(mem_word[15:10]))
        else $error("opcode not taken from fetched word");
    opcode_hold_a: assert property (mem_word_vld && !phase_onehot[0] |=>
        $stable(opcode) && transfer_word == $past(mem_word))
        else $error("operand read did not keep opcode or load word");
    field_direct_a: assert property (operand_field == transfer_word[9:0])
        else $error("decoder field differs from transfer word");
endmodule : seq_chk

bind machine_cycle_phase_sequencer seq_chk seq_chk_inst (.*);

// [core_mem_model.sv]
// Purpose: Core memory sense side answering the sequencer's read pulses
// Assumes: One word per read pulse, taken from the bench
// Notes:   Between strobes the data lines toggle so stale data never looks valid
`timescale 1ns/1ps
module core_mem_model (
    input  wire logic        core_clk,       // Clock
    input  wire logic        sys_rst,        // Async reset
    input  wire logic        mem_read_pulse, // Read control from sequencer
    input  wire logic [15:0] word_in,        // Word held at the addressed place
    output logic      [15:0] mem_word,       // Sense data toward the block
    output logic             mem_word_vld    // One-cycle strobe with data
);
    logic read_d_r; // Read pulse one cycle ago

    // Strobe once at the start of each read pulse, otherwise toggle the lines
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            read_d_r     <= 1'b0;
            mem_word_vld <= 1'b0;
            mem_word     <= 16'h0000;
        end else begin
            read_d_r     <= mem_read_pulse;
            mem_word_vld <= mem_read_pulse && !read_d_r;
            mem_word     <= (mem_read_pulse && !read_d_r) ? word_in : ~mem_word;
        end
    end
endmodule : core_mem_model

// [tb_top.sv]
// Purpose: Directed run of ring start-up, phase sequencing and word handling
// Assumes: Options absent, run held high, panel inputs idle
// Notes:   Each cyc call checks the phase of the cycle it supplies a word to
`timescale 1ns/1ps
module tb_top;
    logic                   core_clk, sys_rst, ring_scramble, run, int_req_pin, dma_req_pin;
    logic [7:0]             ring_seed;
    logic [15:0]            word_in, mem_word, transfer_word;
    logic                   mem_word_vld, clock_phase_a, clock_phase_b, seventh_time_period;
    logic                   late_cycle_strobe, memory_write_level, mem_read_pulse;
    logic                   mem_write_pulse, ring_stage_wrap, ring_stage_first_pair;
    logic                   first_double_period_pulse, phase_dma, instr_done;
    logic [3:0]             phase_onehot;
    logic [5:0]             opcode;
    logic [9:0]             operand_field;
    logic [14:0]            addr_out;
    cycle_seq_pkg::decode_s decode;
    cycle_seq_pkg::timing_s timing;
    int                     num_errors, tests_run;
    localparam cycle_seq_pkg::decode_s SGL = 4'b0010; // Register-only, read
    localparam cycle_seq_pkg::decode_s MR  = 4'b1110; // Memory reference, read
    localparam cycle_seq_pkg::decode_s MRW = 4'b1111; // Memory reference, read and write

    machine_cycle_phase_sequencer machine_cycle_phase_sequencer_inst (
        .panel_read(1'b0), .panel_write(1'b0), .eau_write_en(1'b0), .pc_value(15'h1234), .*);
    core_mem_model core_mem_model_inst (.*);

    // Verdict and end of run
    task automatic wrap_up;
        if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up

    // Compare and report
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Wait, bounded, until one period pulse reaches a level
    task automatic wait_bit(input int idx, input logic lvl);
        int n;
        n = 0;
        #1;
        while (timing.period[idx] !== lvl) begin
            @(posedge core_clk);
            #1;
            n++;
            if (n > 40) begin
                num_errors++;
                wrap_up();
            end
        end
    endtask : wait_bit

    // Check phase at cycle start, then offer the word and decoder levels
    task automatic cyc(input logic [15:0] w, input cycle_seq_pkg::decode_s d,
                       input logic [3:0] ph);
        wait_bit(0, 1'b0);
        wait_bit(0, 1'b1);
        check({12'h000, phase_onehot}, {12'h000, ph});
        @(posedge core_clk);
        word_in <= w;
        decode  <= d;
    endtask : cyc

    // Reset for four cycles, then follow the start-up walk from period six
    task automatic do_reset;
        sys_rst <= 1'b1;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            #1;
            check({8'h00, timing.period}, {8'h00, 8'h01 << ((6 + i / 2) % 8)});
            check({15'h0000, late_cycle_strobe}, (i == 3) ? 16'h0001 : 16'h0000);
        end
        @(posedge core_clk);
    endtask : do_reset

    // Free-running clock
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        wrap_up();
    end

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        ring_scramble = 1'b0;
        ring_seed = 8'h00;
        run = 1'b1;
        int_req_pin = 1'b0;
        dma_req_pin = 1'b0;
        word_in = 16'h0000;
        decode = SGL;
        num_errors = 0;
        tests_run = 0;
        do_reset();
        cyc(16'h1c00, SGL, 4'b0001);
        cyc(16'h8005, SGL, 4'b0001);
        check({10'h000, opcode}, 16'h0007);
        check({1'b0, addr_out}, 16'h1234);
        cyc(16'h2000, MRW, 4'b0001);
        check({10'h000, opcode}, 16'h0020);
        cyc(16'h0abc, MRW, 4'b0100);
        check(transfer_word, 16'h2000);
        wait_bit(1, 1'b1);
        check({15'h0000, mem_read_pulse}, 16'h0001);
        wait_bit(5, 1'b1);
        check({15'h0000, mem_write_pulse}, 16'h0001);
        cyc(16'h0000, SGL, 4'b0001);
        check({10'h000, opcode}, 16'h0008);
        check(transfer_word, 16'h0abc);
        int_req_pin <= 1'b1;
        cyc(16'h0000, SGL, 4'b1000);
        int_req_pin <= 1'b0;
        dma_req_pin <= 1'b1;
        wait_bit(0, 1'b0);
        wait_bit(0, 1'b1);
        check({15'h0000, phase_dma}, 16'h0001);
        @(posedge core_clk);
        dma_req_pin <= 1'b0;
        cyc(16'h8123, MR, 4'b0001);
        cyc(16'h8456, MR, 4'b0010);
        cyc(16'h0789, MR, 4'b0010);
        cyc(16'h1111, MR, 4'b0010);
        cyc(16'h0000, SGL, 4'b0100);
        foreach (ring_seed[i]) begin
            @(posedge core_clk);
            ring_scramble <= (i < 3);
            ring_seed <= 8'hff >> i;
            @(posedge core_clk);
            ring_scramble <= 1'b0;
            repeat (18) @(posedge core_clk);
            #1;
            check({15'h0000, $onehot(timing.period)}, 16'h0001);
        end
        do_reset();
        cyc(16'h0000, SGL, 4'b0001);
        wrap_up();
    end
endmodule : tb_top
